/* common/ecjs_pkg.sv */
// Package: register map, field layout and constants of the EQ and jack-sense block
package ecjs_pkg;

	// ------------------------------------------------------------
	// Register indices and byte addresses
	// ------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 16;
	localparam logic [7:0] IDX_EQ_CTRL = 8'h60;
	localparam logic [7:0] IDX_COEF = 8'h62;
	localparam logic [7:0] IDX_MISC2 = 8'h70;
	localparam logic [7:0] IDX_JACK = 8'h72;
	localparam logic [7:0] IDX_IRQ_PATH = 8'h80;
	localparam logic [ADDR_W-1:0] ADDR_EQ_CTRL = {2'h0, IDX_EQ_CTRL, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_COEF = {2'h0, IDX_COEF, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_MISC2 = {2'h0, IDX_MISC2, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_JACK = {2'h0, IDX_JACK, 2'h0};
	localparam logic [ADDR_W-1:0] ADDR_IRQ_PATH = {2'h0, IDX_IRQ_PATH, 2'h0};

	// ------------------------------------------------------------
	// Reset values and writable masks
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] EQ_CTRL_RST = 16'h8080;
	localparam logic [DATA_W-1:0] MISC2_RST = 16'h0000;
	localparam logic [DATA_W-1:0] JACK_RST = 16'h0000;
	localparam logic [DATA_W-1:0] EQ_CTRL_WMASK = 16'h80ff;
	localparam logic [DATA_W-1:0] MISC2_WMASK = 16'h1cbc;
	localparam logic [DATA_W-1:0] JACK_RW_MASK = 16'hff30;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int EQ_OFF_BIT = 15;
	localparam int MIRROR_BIT = 7;
	localparam int BANK_BIT = 6;
	localparam int PTR_W = 6;
	localparam int BIAS_W = 3;
	localparam int MIC_BIAS_LSB = 10;
	localparam int CENTER_BIAS_LSB = 2;
	localparam int ALT_MAP_BIT = 5;
	localparam int AUTOMUTE_OFF_BIT = 7;
	localparam int FLAG_LSB = 0;
	localparam int LEVEL_LSB = 2;
	localparam int MODE_LSB = 4;
	localparam int SKIP_LSB = 8;
	localparam int LINES = 2;

	// ------------------------------------------------------------
	// Bias codes, coefficient map, timing, bus answers
	// ------------------------------------------------------------
	localparam logic [BIAS_W-1:0] BIAS_2V25 = 3'h1;
	localparam logic [BIAS_W-1:0] BIAS_0V = 3'h2;
	localparam logic [BIAS_W-1:0] BIAS_3V70 = 3'h4;
	localparam logic [PTR_W-1:0] COEF_FIRST = 6'h19;
	localparam logic [PTR_W-1:0] COEF_LAST = 6'h3b;
	localparam int COEF_WORDS = 35;
	localparam int DEBOUNCE_SAMPLES = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* common/ecjs_coef_if.sv */
// Interface: coefficient memory access between register logic and storage
`timescale 1ns/1ps
interface ecjs_coef_if;
	logic wr;
	logic bank;
	logic mirror;
	logic [ecjs_pkg::PTR_W-1:0] ptr;
	logic [ecjs_pkg::DATA_W-1:0] wdata;
	logic [ecjs_pkg::DATA_W-1:0] rdata;
	modport ctrl (output wr, output bank, output mirror, output ptr, output wdata, input rdata);
	modport mem (input wr, input bank, input mirror, input ptr, input wdata, output rdata);
endinterface

/* design/ecjs_coef_mem.sv */
// Module: two banks of biquad coefficient words held in flip-flops
`timescale 1ns/1ps
module ecjs_coef_mem #(
	parameter int WORDS = ecjs_pkg::COEF_WORDS
) (
	input wire logic clk,
	input wire logic rst_n,
	ecjs_coef_if.mem cif
);

	typedef struct packed {
		logic [1:0][WORDS-1:0][ecjs_pkg::DATA_W-1:0] word;
	} ecjs_mem_t;

	ecjs_mem_t s_reg;
	ecjs_mem_t s_next;
	logic hit;
	logic [ecjs_pkg::PTR_W-1:0] idx;

	// ------------------------------------------------------------
	// Pointer decode
	// ------------------------------------------------------------
	// Codes outside the biquad range read zero and drop writes
	assign hit = (cif.ptr >= ecjs_pkg::COEF_FIRST) && (cif.ptr <= ecjs_pkg::COEF_LAST);
	assign idx = cif.ptr - ecjs_pkg::COEF_FIRST;
	assign cif.rdata = hit ? s_reg.word[cif.bank][idx] : '0;

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		if (cif.wr && hit) begin
			s_next.word[cif.bank][idx] = cif.wdata;
			if (cif.mirror && !cif.bank) begin
				s_next.word[1][idx] = cif.wdata;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

endmodule // ecjs_coef_mem

/* design/ecjs_regs.sv */
// Module: EQ coefficient transfer, bias selects and jack-sense registers on AXI4-Lite
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module ecjs_regs #(
	parameter int DEBOUNCE = ecjs_pkg::DEBOUNCE_SAMPLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [ecjs_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ecjs_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sense_line_zero,
	input wire logic sense_line_one,
	output logic eq_pass_through,
	output logic [ecjs_pkg::BIAS_W-1:0] center_bias_select,
	output logic [ecjs_pkg::BIAS_W-1:0] mic_bias_select,
	output logic center_bias_drive_2v25,
	output logic center_bias_drive_0v,
	output logic center_bias_drive_3v70,
	output logic mic_bias_drive_2v25,
	output logic mic_bias_drive_0v,
	output logic mic_bias_drive_3v70,
	output logic detect_tree_alt_map,
	output logic single_channel_automute_off,
	output logic sense_zero_level,
	output logic sense_one_level,
	output logic slot12_irq,
	output logic slot6_irq
);

	localparam int CNT_W = $clog2(DEBOUNCE + 1);
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DEBOUNCE - 1);
	localparam int L = ecjs_pkg::LINES;
	localparam int DW = ecjs_pkg::DATA_W;
	localparam int AW = ecjs_pkg::ADDR_W;

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		logic awrdy;
		logic wrdy;
		logic arrdy;
		logic aw_held;
		logic [AW-1:0] aw_addr;
		logic w_held;
		logic [DW-1:0] w_data;
		logic [1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [DW-1:0] rdata;
		logic [1:0] rresp;
		logic [DW-1:0] eq_ctrl;
		logic [DW-1:0] misc2;
		logic [DW-1:0] jack;
		logic path_sel;
		logic [L-1:0] s1;
		logic [L-1:0] s2;
		logic [L-1:0] s3;
		logic [L-1:0] level;
		logic [L-1:0][CNT_W-1:0] cnt;
		logic eq_pass;
		logic [2:0] c_drive;
		logic [2:0] m_drive;
		logic irq12;
		logic irq6;
	} ecjs_state_t;

	ecjs_state_t s_reg;
	ecjs_state_t s_next;

	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_wr;
	logic [AW-1:0] wr_addr;
	logic [AW-1:0] rd_addr;
	logic [DW-1:0] wr_word;
	logic [DW-1:0] rd_word;
	logic rd_ok;
	logic coef_wr;
	logic [DW-1:0] coef_wdata;
	logic [L-1:0] evt;
	logic [L-1:0] clr;
	logic irq_any;

	ecjs_coef_if cif ();

	ecjs_coef_mem #(
		.WORDS(ecjs_pkg::COEF_WORDS)
	) u_mem (
		.clk(clk),
		.rst_n(rst_n),
		.cif(cif)
	);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [DW-1:0] merge(input logic [DW-1:0] old, input logic [DW-1:0] nw,
		input logic [1:0] strb);
		logic [DW-1:0] r;
		r = old;
		if (strb[0]) begin
			r[7:0] = nw[7:0];
		end
		if (strb[1]) begin
			r[15:8] = nw[15:8];
		end
		return r;
	endfunction

	// Illegal codes leave the pin undriven rather than guess a level
	function automatic logic [2:0] bias_decode(input logic [ecjs_pkg::BIAS_W-1:0] code);
		logic [2:0] d;
		d = 3'h0;
		if (code == ecjs_pkg::BIAS_2V25) begin
			d = 3'h1;
		end else if (code == ecjs_pkg::BIAS_0V) begin
			d = 3'h2;
		end else if (code == ecjs_pkg::BIAS_3V70) begin
			d = 3'h4;
		end
		return d;
	endfunction

	// ------------------------------------------------------------
	// Coefficient port
	// ------------------------------------------------------------
	assign cif.wr = coef_wr;
	assign cif.bank = s_reg.eq_ctrl[ecjs_pkg::BANK_BIT];
	assign cif.mirror = s_reg.eq_ctrl[ecjs_pkg::MIRROR_BIT];
	assign cif.ptr = s_reg.eq_ctrl[ecjs_pkg::PTR_W-1:0];
	assign cif.wdata = coef_wdata;

	// ------------------------------------------------------------
	// Read mux
	// ------------------------------------------------------------
	assign rd_addr = {s_axi_araddr[AW-1:2], 2'h0};

	always_comb begin
		rd_word = '0;
		rd_ok = 1'b1;
		case (rd_addr)
			ecjs_pkg::ADDR_EQ_CTRL: begin
				rd_word = s_reg.eq_ctrl;
			end
			ecjs_pkg::ADDR_COEF: begin
				rd_word = cif.rdata;
			end
			ecjs_pkg::ADDR_MISC2: begin
				rd_word = s_reg.misc2;
			end
			ecjs_pkg::ADDR_JACK: begin
				rd_word = s_reg.jack;
				rd_word[ecjs_pkg::LEVEL_LSB +: L] = s_reg.level;
			end
			ecjs_pkg::ADDR_IRQ_PATH: begin
				rd_word[0] = s_reg.path_sel;
			end
			default: begin
				rd_ok = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_next = s_reg;
		coef_wr = 1'b0;
		coef_wdata = '0;
		clr = '0;
		evt = '0;
		aw_hs = s_axi_awvalid && s_reg.awrdy;
		w_hs = s_axi_wvalid && s_reg.wrdy;
		ar_hs = s_axi_arvalid && s_reg.arrdy;

		// Write channel capture, address and data in either order
		if (aw_hs) begin
			s_next.aw_held = 1'b1;
			s_next.aw_addr = {s_axi_awaddr[AW-1:2], 2'h0};
		end
		if (w_hs) begin
			s_next.w_held = 1'b1;
			s_next.w_data = s_axi_wdata[DW-1:0];
			s_next.w_strb = s_axi_wstrb[1:0];
		end
		if (s_reg.bvalid && s_axi_bready) begin
			s_next.bvalid = 1'b0;
		end
		do_wr = s_next.aw_held && s_next.w_held && !s_reg.bvalid;
		wr_addr = s_next.aw_addr;
		wr_word = merge('0, s_next.w_data, s_next.w_strb);

		if (do_wr) begin
			s_next.aw_held = 1'b0;
			s_next.w_held = 1'b0;
			s_next.bvalid = 1'b1;
			s_next.bresp = ecjs_pkg::RESP_OKAY;
			case (wr_addr)
				ecjs_pkg::ADDR_EQ_CTRL: begin
					s_next.eq_ctrl = merge(s_reg.eq_ctrl, s_next.w_data, s_next.w_strb)
						& ecjs_pkg::EQ_CTRL_WMASK;
				end
				ecjs_pkg::ADDR_COEF: begin
					// Live filter must never see a half-loaded set
					coef_wr = s_reg.eq_ctrl[ecjs_pkg::EQ_OFF_BIT];
					coef_wdata = merge(cif.rdata, s_next.w_data, s_next.w_strb);
				end
				ecjs_pkg::ADDR_MISC2: begin
					s_next.misc2 = merge(s_reg.misc2, s_next.w_data, s_next.w_strb)
						& ecjs_pkg::MISC2_WMASK;
				end
				ecjs_pkg::ADDR_JACK: begin
					s_next.jack = (merge(s_reg.jack, s_next.w_data, s_next.w_strb)
						& ecjs_pkg::JACK_RW_MASK)
						| (s_reg.jack & ~ecjs_pkg::JACK_RW_MASK);
					clr = wr_word[ecjs_pkg::FLAG_LSB +: L];
				end
				ecjs_pkg::ADDR_IRQ_PATH: begin
					if (s_next.w_strb[0]) begin
						s_next.path_sel = s_next.w_data[0];
					end
				end
				default: begin
					s_next.bresp = ecjs_pkg::RESP_SLVERR;
				end
			endcase
		end
		s_next.awrdy = !s_next.aw_held && !s_next.bvalid;
		s_next.wrdy = !s_next.w_held && !s_next.bvalid;

		// Read channel
		if (s_reg.rvalid && s_axi_rready) begin
			s_next.rvalid = 1'b0;
		end
		if (ar_hs) begin
			s_next.rvalid = 1'b1;
			s_next.rdata = rd_word;
			s_next.rresp = rd_ok ? ecjs_pkg::RESP_OKAY : ecjs_pkg::RESP_SLVERR;
		end
		s_next.arrdy = !s_next.rvalid;

		// Sense lines: three-stage sync, then a stable run
		s_next.s1 = {sense_line_one, sense_line_zero};
		s_next.s2 = s_reg.s1;
		s_next.s3 = s_reg.s2;
		for (int i = 0; i < L; i++) begin
			if ((s_reg.s2[i] == s_reg.s3[i]) && (s_reg.s3[i] != s_reg.level[i])) begin
				if (s_reg.cnt[i] == CNT_LAST) begin
					s_next.cnt[i] = '0;
					s_next.level[i] = s_reg.s3[i];
					evt[i] = 1'b1;
				end else begin
					s_next.cnt[i] = s_reg.cnt[i] + 1'b1;
				end
			end else begin
				s_next.cnt[i] = '0;
			end
		end

		// Event flags: a new event beats a clear in the same cycle
		s_next.jack[ecjs_pkg::FLAG_LSB +: L] = (s_reg.jack[ecjs_pkg::FLAG_LSB +: L] & ~clr) | evt;

		// Outputs registered from next values
		s_next.eq_pass = s_next.eq_ctrl[ecjs_pkg::EQ_OFF_BIT]
			| (|(s_next.jack[ecjs_pkg::SKIP_LSB +: L] & s_next.level));
		s_next.c_drive = bias_decode(s_next.misc2[ecjs_pkg::CENTER_BIAS_LSB +: ecjs_pkg::BIAS_W]);
		s_next.m_drive = bias_decode(s_next.misc2[ecjs_pkg::MIC_BIAS_LSB +: ecjs_pkg::BIAS_W]);
		irq_any = |(s_next.jack[ecjs_pkg::FLAG_LSB +: L] & s_next.jack[ecjs_pkg::MODE_LSB +: L]);
		s_next.irq12 = irq_any && !s_next.path_sel;
		s_next.irq6 = irq_any && s_next.path_sel;
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_reg <= '0;
			s_reg.eq_ctrl <= ecjs_pkg::EQ_CTRL_RST;
			s_reg.misc2 <= ecjs_pkg::MISC2_RST;
			s_reg.jack <= ecjs_pkg::JACK_RST;
			s_reg.eq_pass <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	// ------------------------------------------------------------
	// Port mapping
	// ------------------------------------------------------------
	assign s_axi_awready = s_reg.awrdy;
	assign s_axi_wready = s_reg.wrdy;
	assign s_axi_arready = s_reg.arrdy;
	assign s_axi_bvalid = s_reg.bvalid;
	assign s_axi_bresp = s_reg.bresp;
	assign s_axi_rvalid = s_reg.rvalid;
	assign s_axi_rresp = s_reg.rresp;
	assign s_axi_rdata = {16'h0000, s_reg.rdata};
	assign eq_pass_through = s_reg.eq_pass;
	assign center_bias_select = s_reg.misc2[ecjs_pkg::CENTER_BIAS_LSB +: ecjs_pkg::BIAS_W];
	assign mic_bias_select = s_reg.misc2[ecjs_pkg::MIC_BIAS_LSB +: ecjs_pkg::BIAS_W];
	assign center_bias_drive_2v25 = s_reg.c_drive[0];
	assign center_bias_drive_0v = s_reg.c_drive[1];
	assign center_bias_drive_3v70 = s_reg.c_drive[2];
	assign mic_bias_drive_2v25 = s_reg.m_drive[0];
	assign mic_bias_drive_0v = s_reg.m_drive[1];
	assign mic_bias_drive_3v70 = s_reg.m_drive[2];
	assign detect_tree_alt_map = s_reg.misc2[ecjs_pkg::ALT_MAP_BIT];
	assign single_channel_automute_off = s_reg.misc2[ecjs_pkg::AUTOMUTE_OFF_BIT];
	assign sense_zero_level = s_reg.level[0];
	assign sense_one_level = s_reg.level[1];
	assign slot12_irq = s_reg.irq12;
	assign slot6_irq = s_reg.irq6;

endmodule // ecjs_regs

/* dv/ecjs_jack_model.sv */
// Partner model: jack switches whose contacts chatter before they settle
`timescale 1ns/1ps
module ecjs_jack_model #(
	parameter int BOUNCE = 3
) (
	input wire logic clk,
	input wire logic [1:0] plug,
	output logic [1:0] line
);
	logic [1:0] last;
	int cnt [2];
	// ------------------------------------------------------------
	// Contact chatter, then the settled level
	// ------------------------------------------------------------
	// Open jack is pulled low, inserted plug reads high
	initial begin
		line = 2'h0;
		last = 2'h0;
		cnt = '{0, 0};
	end
	always @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			// Toggling every cycle so a raw edge never looks settled
			if (plug[i] !== last[i]) begin
				last[i] <= plug[i];
				cnt[i] <= BOUNCE;
			end else if (cnt[i] > 0) begin
				line[i] <= ~line[i];
				cnt[i] <= cnt[i] - 1;
			end else begin
				line[i] <= last[i];
			end
		end
	end
endmodule // ecjs_jack_model

/* dv/ecjs_regs_properties.sv */
// Checker: bus answers, bias drives, line-zero jack level and irq routing at the block ports
`timescale 1ns/1ps
module ecjs_regs_checker #(
	parameter int DEBOUNCE = ecjs_pkg::DEBOUNCE_SAMPLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sense_line_zero,
	input wire logic sense_zero_level,
	input wire logic [2:0] center_bias_select,
	input wire logic [2:0] mic_bias_select,
	input wire logic center_bias_drive_2v25,
	input wire logic center_bias_drive_0v,
	input wire logic center_bias_drive_3v70,
	input wire logic mic_bias_drive_2v25,
	input wire logic mic_bias_drive_0v,
	input wire logic mic_bias_drive_3v70,
	input wire logic slot12_irq,
	input wire logic slot6_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ------------------------------------------------------------
	// Sequences and properties
	// ------------------------------------------------------------
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_b_held;
		s_axi_bvalid && $stable(s_axi_bresp);
	endsequence
	property p_write_answer;
		s_wr_taken |=> s_axi_bvalid && !s_axi_awready;
	endproperty
	property p_b_stands;
		s_axi_bvalid && !s_axi_bready |=> s_b_held;
	endproperty
	property p_read_answer;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
	endproperty
	property p_r_stands;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	property p_r_width;
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000;
	endproperty
	property p_center_bias;
		(center_bias_select == ecjs_pkg::BIAS_3V70) [*2] |->
			center_bias_drive_3v70 && !center_bias_drive_0v && !center_bias_drive_2v25;
	endproperty
	property p_mic_bias;
		(mic_bias_select == ecjs_pkg::BIAS_0V) [*2] |-> mic_bias_drive_0v && !mic_bias_drive_2v25 && !mic_bias_drive_3v70;
	endproperty
	property p_irq_single;
		!(slot12_irq && slot6_irq);
	endproperty
	// Settled pin must have stood for samples before the level moves
	property p_level_debounce;
		$changed(sense_zero_level) |->
			$past(sense_line_zero, 3) == sense_zero_level && $past(sense_line_zero, 4) == sense_zero_level;
	endproperty
	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	a_write_answer: assert property (p_write_answer) else $error("write answer missing");
	a_b_stands: assert property (p_b_stands) else $error("write response dropped");
	a_read_answer: assert property (p_read_answer) else $error("read answer missing");
	a_r_stands: assert property (p_r_stands) else $error("read data dropped");
	a_r_width: assert property (p_r_width) else $error("read data above bit 15");
	a_center_bias: assert property (p_center_bias) else $error("center bias drive wrong");
	a_mic_bias: assert property (p_mic_bias) else $error("mic bias drive wrong");
	a_irq_single: assert property (p_irq_single) else $error("irq on both paths");
	a_level_debounce: assert property (p_level_debounce) else $error("level moved without settled pin");
endmodule // ecjs_regs_checker
bind ecjs_regs ecjs_regs_checker #(
	.DEBOUNCE(DEBOUNCE)
) u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.sense_line_zero(sense_line_zero),
	.sense_zero_level(sense_zero_level),
	.center_bias_select(center_bias_select),
	.mic_bias_select(mic_bias_select),
	.center_bias_drive_2v25(center_bias_drive_2v25),
	.center_bias_drive_0v(center_bias_drive_0v),
	.center_bias_drive_3v70(center_bias_drive_3v70),
	.mic_bias_drive_2v25(mic_bias_drive_2v25),
	.mic_bias_drive_0v(mic_bias_drive_0v),
	.mic_bias_drive_3v70(mic_bias_drive_3v70),
	.slot12_irq(slot12_irq),
	.slot6_irq(slot6_irq)
);

/* dv/ecjs_regs_tb_top.sv */
// Testbench: register traffic over AXI4-Lite against EQ, bias and jack-sense rules
`timescale 1ns/1ps
module ecjs_regs_tb_top;
	logic clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, eq_pass_through;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot, center_bias_select, mic_bias_select;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, plug, lines;
	logic center_bias_drive_2v25, center_bias_drive_0v, center_bias_drive_3v70;
	logic mic_bias_drive_2v25, mic_bias_drive_0v, mic_bias_drive_3v70;
	logic detect_tree_alt_map, single_channel_automute_off, sense_zero_level, sense_one_level;
	logic slot12_irq, slot6_irq;
	wire sense_line_zero = lines[0];
	wire sense_line_one = lines[1];
	int err_count, check_count;
	logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
	logic [2:0] c;
	logic [15:0] v;
	// Short debounce keeps the run brief
	ecjs_regs #(.DEBOUNCE(2)) DUT (.*);
	ecjs_jack_model u_jack (.clk(clk), .plug(plug), .line(lines));
	always #12.5 clk = ~clk;
	// ------------------------------------------------------------
	// Compare, verdict, bus tasks
	// ------------------------------------------------------------
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			err_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// Ready is looked at on the falling edge, so the handshake edge is the next rising one
	task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
		logic pa, pw;
		pa = 1;
		pw = 1;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		while (pa || pw) begin
			@(negedge clk);
			if (s_axi_awvalid && s_axi_awready) pa = 0;
			if (s_axi_wvalid && s_axi_wready) pw = 0;
			@(posedge clk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		@(negedge clk);
		while (!s_axi_bvalid) @(negedge clk);
		chk("bresp", s_axi_bresp, er);
		@(posedge clk);
		s_axi_bready <= 0;
	endtask
	task rd(input logic [11:0] a, input logic [15:0] e, input logic [1:0] er);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		@(negedge clk);
		while (!s_axi_arready) @(negedge clk);
		@(posedge clk);
		s_axi_arvalid <= 0;
		@(negedge clk);
		while (!s_axi_rvalid) @(negedge clk);
		chk("rdata", s_axi_rdata, {16'h0000, e});
		chk("rresp", s_axi_rresp, er);
		@(posedge clk);
		s_axi_rready <= 0;
	endtask
	task settle(input logic [1:0] p);
		@(posedge clk);
		plug <= p;
		repeat (20) @(posedge clk);
	endtask
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		clk = 1'h0;
		rst_n = 1'h0;
		plug = 2'h0;
		s_axi_awaddr = 12'h000;
		s_axi_awprot = 3'h0;
		s_axi_awvalid = 1'h0;
		s_axi_wdata = 32'h00000000;
		s_axi_wstrb = 4'h3;
		s_axi_wvalid = 1'h0;
		s_axi_bready = 1'h0;
		s_axi_araddr = 12'h000;
		s_axi_arprot = 3'h0;
		s_axi_arvalid = 1'h0;
		s_axi_rready = 1'h0;
		err_count = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1;
		repeat (2) @(posedge clk);
		chk("pass", eq_pass_through, 1);
		rd(ecjs_pkg::ADDR_EQ_CTRL, 16'h8080, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_MISC2, 16'h0000, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_JACK, 16'h0000, ecjs_pkg::RESP_OKAY);
		rd(12'h004, 16'h0000, ecjs_pkg::RESP_SLVERR);
		wr(12'h004, 16'hffff, ecjs_pkg::RESP_SLVERR);
		// Mirrored load of the first word, read back from the right block
		wr(ecjs_pkg::ADDR_EQ_CTRL, 16'h8099, ecjs_pkg::RESP_OKAY);
		wr(ecjs_pkg::ADDR_COEF, 16'ha5c3, ecjs_pkg::RESP_OKAY);
		wr(ecjs_pkg::ADDR_EQ_CTRL, 16'h80d9, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_COEF, 16'ha5c3, ecjs_pkg::RESP_OKAY);
		// Last word, left only; right stays at its reset content
		wr(ecjs_pkg::ADDR_EQ_CTRL, 16'h803b, ecjs_pkg::RESP_OKAY);
		wr(ecjs_pkg::ADDR_COEF, 16'h1234, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_COEF, 16'h1234, ecjs_pkg::RESP_OKAY);
		wr(ecjs_pkg::ADDR_EQ_CTRL, 16'h807b, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_COEF, 16'h0000, ecjs_pkg::RESP_OKAY);
		wr(ecjs_pkg::ADDR_EQ_CTRL, 16'h8018, ecjs_pkg::RESP_OKAY);
		wr(ecjs_pkg::ADDR_COEF, 16'hffff, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_COEF, 16'h0000, ecjs_pkg::RESP_OKAY);
		wr(ecjs_pkg::ADDR_EQ_CTRL, 16'h003b, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_EQ_CTRL, 16'h003b, ecjs_pkg::RESP_OKAY);
		chk("pass", eq_pass_through, 0);
		wr(ecjs_pkg::ADDR_COEF, 16'h5555, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_COEF, 16'h1234, ecjs_pkg::RESP_OKAY);
		for (int i = 0; i < 4; i++) begin
			c = codes[i];
			v = {3'h0, c, 2'h0, i[0], 1'b0, i[1], c, 2'h0};
			wr(ecjs_pkg::ADDR_MISC2, v, ecjs_pkg::RESP_OKAY);
			rd(ecjs_pkg::ADDR_MISC2, v, ecjs_pkg::RESP_OKAY);
			chk("csel", center_bias_select, c);
			chk("cdrv", {center_bias_drive_3v70, center_bias_drive_0v, center_bias_drive_2v25}, c);
			chk("mdrv", {mic_bias_drive_3v70, mic_bias_drive_0v, mic_bias_drive_2v25}, c);
			chk("msel", mic_bias_select, c);
			chk("map", detect_tree_alt_map, i[1]);
			chk("mute", single_channel_automute_off, i[0]);
		end
		wr(ecjs_pkg::ADDR_JACK, 16'hff3f, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_JACK, 16'hff30, ecjs_pkg::RESP_OKAY);
		settle(2'h1);
		rd(ecjs_pkg::ADDR_JACK, 16'hff35, ecjs_pkg::RESP_OKAY);
		chk("lvl0", sense_zero_level, 1);
		chk("irq12", slot12_irq, 1);
		chk("irq6", slot6_irq, 0);
		chk("pass", eq_pass_through, 1);
		wr(ecjs_pkg::ADDR_JACK, 16'hff31, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_JACK, 16'hff34, ecjs_pkg::RESP_OKAY);
		chk("irq12", slot12_irq, 0);
		wr(ecjs_pkg::ADDR_IRQ_PATH, 16'h0001, ecjs_pkg::RESP_OKAY);
		settle(2'h3);
		rd(ecjs_pkg::ADDR_JACK, 16'hff3e, ecjs_pkg::RESP_OKAY);
		chk("lvl1", sense_one_level, 1);
		chk("irq6", slot6_irq, 1);
		chk("irq12", slot12_irq, 0);
		// Polled mode: flag sets on the falling line but no irq
		wr(ecjs_pkg::ADDR_JACK, 16'h0302, ecjs_pkg::RESP_OKAY);
		rd(ecjs_pkg::ADDR_JACK, 16'h030c, ecjs_pkg::RESP_OKAY);
		settle(2'h2);
		rd(ecjs_pkg::ADDR_JACK, 16'h0309, ecjs_pkg::RESP_OKAY);
		chk("irq6", slot6_irq, 0);
		chk("pass", eq_pass_through, 1);
		end_of_test();
	end
	initial begin
		#200000;
		err_count++;
		end_of_test();
	end
endmodule // ecjs_regs_tb_top
